// ===== bench/host_model.sv
// host model issuing single-byte accesses on the register port
`timescale 1ns/100ps
module host_model
(
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	output logic rd_o,
	output logic wr_o,
	output logic [7:0] addr_o
);
	initial
	begin
		rd_o = 1'b0;
		wr_o = 1'b0;
		addr_o = 8'h00;
	end
	// one request cycle, data taken after the answering edge
	task automatic access(input logic [7:0] a, input logic w, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		addr_o = a;
		rd_o = !w;
		wr_o = w;
		@(posedge clk_i);
		#1;
		d = rdata_i;
		rd_o = 1'b0;
		wr_o = 1'b0;
		// released address no longer shows the last value
		addr_o = ~a;
	endtask
endmodule

// ===== bench/typec_state_fault_status_tb.sv
// self-checking bench for the state window and fault change flags
`timescale 1ns/100ps
module typec_state_fault_status_tb;
	import typec_state_fault_pkg::*;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ce_i = 1'b1;
	logic orient_i = 1'b0;
	logic role = 1'b0;
	state_code_t norm = 5'h08;
	state_code_t stby = 5'h08;
	logic [7:0] fault = 8'h00;
	logic hot = 1'b0;
	logic mask = 1'b1;
	logic rd, wr, line, code_orient, summary, alert_n;
	logic [7:0] addr, rdata, d, acc;
	state_code_t code;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	state_code_t codes [10] = '{5'h08, 5'h09, 5'h0A, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h13,
		5'h18, 5'h19};
	int fmap [8] = '{0, 0, 1, 1, 2, 2, 4, 5};
	int exp_q [$];
	// model of the operation status byte built from the rules
	function automatic logic [7:0] op_model(input logic o, input state_code_t c);
		return {o, 2'b00, c};
	endfunction
	always #5 clk_i = ~clk_i;
	host_model host (.clk_i(clk_i), .rdata_i(rdata), .rd_o(rd), .wr_o(wr), .addr_o(addr));
	typec_state_fault_status DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
		.reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr), .reg_rdata_o(rdata),
		.orient_i(orient_i), .role_config_register_i(role), .state_code_normal_i(norm),
		.state_code_standby_i(stby), .fault_status_register_i(fault), .over_temp_i(hot),
		.fault_alert_mask_i(mask), .active_line_select_o(line),
		.connection_state_code_o(code), .orientation_o(code_orient),
		.fault_alert_summary_o(summary), .alert_n_o(alert_n));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			test_done();
		end
	end
	initial
	begin
		void'($urandom(70588));
		repeat (16) @(posedge clk_i);
		#1;
		rstn_i = 1'b1;
		host.access(8'h11, 1'b0, d);
		chk(d, 8'h08);
		host.access(8'h12, 1'b0, d);
		chk(d, 8'h00);
		host.access(8'h11, 1'b1, d);
		host.access(8'h11, 1'b0, d);
		chk(d, 8'h08);
		host.access(8'h13, 1'b0, d);
		chk(d, 8'h00);
		for (int i = 0; i < 10; i++)
		begin
			role = $urandom;
			orient_i = $urandom;
			norm = role ? codes[9-i] : codes[i];
			stby = role ? codes[i] : codes[9-i];
			@(posedge clk_i);
			@(posedge clk_i);
			#1;
			chk({3'h0, code}, {3'h0, codes[i]});
			chk({7'h00, code_orient}, {7'h00, orient_i});
			host.access(8'h11, 1'b0, d);
			chk(d, op_model(orient_i, codes[i]));
		end
		norm = 5'h1F;
		stby = 5'h0B;
		repeat (3) @(posedge clk_i);
		#1;
		chk({3'h0, code}, {3'h0, codes[9]});
		chk({6'h00, summary, alert_n}, 8'h01);
		for (int j = 0; j < 16; j++)
		begin
			mask = $urandom;
			fault[j%8] = ~fault[j%8];
			exp_q.push_back(1 << fmap[j%8]);
			repeat (8) @(posedge clk_i);
			#1;
			chk({7'h00, summary}, 8'h01);
			chk({7'h00, alert_n}, {7'h00, mask});
			host.access(8'h12, 1'b0, d);
			chk(d, 8'(exp_q.pop_front()));
			host.access(8'h12, 1'b0, d);
			chk(d, 8'h00);
			chk({6'h00, summary, alert_n}, 8'h01);
		end
		hot = 1'b1;
		repeat (8) @(posedge clk_i);
		host.access(8'h12, 1'b0, d);
		chk(d, 8'h80);
		host.access(8'h12, 1'b0, d);
		chk(d, 8'h80);
		hot = 1'b0;
		repeat (8) @(posedge clk_i);
		host.access(8'h12, 1'b0, d);
		host.access(8'h12, 1'b0, d);
		chk(d, 8'h00);
		rstn_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		chk({line, 2'b00, code}, 8'h08);
		rstn_i = 1'b1;
		host.access(8'h11, 1'b0, d);
		chk(d, op_model(orient_i, 5'h08));
		ce_i = 1'b0;
		orient_i = ~orient_i;
		repeat (2) @(posedge clk_i);
		#1;
		chk({7'h00, line}, {7'h00, ~orient_i});
		ce_i = 1'b1;
		@(posedge clk_i);
		#1;
		chk({7'h00, line}, {7'h00, orient_i});
		fault[7] = ~fault[7];
		acc = 8'h00;
		repeat (6)
		begin
			host.access(8'h12, 1'b0, d);
			acc = acc | d;
		end
		chk(acc, 8'h20);
		test_done();
	end
endmodule

// ===== hdl/change_if.sv
// carrier for synchronised levels and their change pulses
`timescale 1ns/100ps
interface change_if #(parameter int WIDTH = 1);
	logic [WIDTH-1:0] level;
	logic [WIDTH-1:0] change;
	modport src (output level, output change);
	modport dst (input level, input change);
endinterface

// ===== hdl/change_sync.sv
// three-stage synchroniser with change detection once stages two and three agree
`timescale 1ns/100ps
module change_sync #(parameter int WIDTH = 1)
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] async_i,
	change_if.src chg
);
	typedef struct packed
	{
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] stable;
		logic [WIDTH-1:0] change;
	} sync_s;

	sync_s q;
	sync_s next_q;
	logic [WIDTH-1:0] settle;

	always_comb
	begin
		next_q = q;
		settle = (~(q.s2 ^ q.s3)) & (q.s3 ^ q.stable);
		if (ce_i)
		begin
			next_q.s1 = async_i;
			next_q.s2 = q.s1;
			next_q.s3 = q.s2;
			next_q.stable = q.stable ^ settle;
			next_q.change = settle;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			q <= '0;
		else
			q <= next_q;
	end

	assign chg.level = q.stable;
	assign chg.change = q.change;
endmodule

// ===== hdl/typec_state_fault_pkg.sv
// types shared by the status and fault-change register bank
package typec_state_fault_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [7:0] reg_addr_t;
	typedef logic [4:0] state_code_t;
	typedef struct packed
	{
		logic line_sel;
		state_code_t code;
		reg_byte_t flags;
		reg_byte_t rdata;
	} bank_state_s;
endpackage

// ===== hdl/typec_state_fault_regs.svh
// register offsets, field positions, reset values and state codes
`ifndef TYPEC_STATE_FAULT_REGS_SVH
`define TYPEC_STATE_FAULT_REGS_SVH
`define OFF_OPERATION_STATE 8'h11
`define OFF_FAULT_CHANGE 8'h12
`define OP_LINE_BIT 7
`define OP_CODE_MSB 4
`define OP_RSVD_ZERO 2'h0
`define OP_STATE_RESET 5'h08
`define CODE_UNATT_SRC 5'h08
`define CODE_WAIT_SRC 5'h09
`define CODE_ATT_SRC 5'h0A
`define CODE_UNATT_ACC 5'h0D
`define CODE_WAIT_ACC 5'h0E
`define CODE_AUDIO_ACC 5'h0F
`define CODE_UNORIENT_DBG 5'h10
`define CODE_ERR_RECOVERY 5'h13
`define CODE_UNATT_WAIT 5'h18
`define CODE_ORIENT_DBG 5'h19
`define FLT_THERMAL_BIT 7
`define FLT_RSVD_HI_BIT 6
`define FLT_PU_OVP_BIT 5
`define FLT_PU_GOOD_BIT 4
`define FLT_RSVD_LO_BIT 3
`define FLT_REV_BIT 2
`define FLT_OCP_BIT 1
`define FLT_OVP_BIT 0
`define STS_PU_OVP 7
`define STS_PU_GOOD 6
`define STS_REV_1 5
`define STS_REV_2 4
`define STS_OCP_1 3
`define STS_OCP_2 2
`define STS_OVP_1 1
`define STS_OVP_2 0
`define FLAGS_RESET 8'h00
`define BYTE_ZERO 8'h00
`endif

// ===== hdl/typec_state_fault_status.sv
// connection state window and read-to-clear fault change flags
`timescale 1ns/100ps
`include "typec_state_fault_regs.svh"

// Behaviour
// - operation status is read-only at offset 11h; writes change nothing
// - bit 7 reports the connected line, 0 first line, 1 second; resets 0
// - the line bit always equals the orientation output pin
// - bits 4:0 carry the connection state code, reset 08h, reserved codes unused
// - reported code follows the variant chosen by the role configuration
// - operation status changes never raise any alert
// - fault change flags at 12h; a read returns them then clears them
// - any fault status bit change, either direction, latches a flag
// - bit 7 sets while junction is over temperature
// - bit 5 sets when pull-up overvoltage status toggles
// - bit 4 sets when pull-up good status toggles
// - bit 2 sets when either cable power reverse-voltage status toggles
// - bit 1 sets when either cable power overcurrent status toggles
// - bit 0 sets when either cable power overvoltage status toggles
// - over temperature alerts through the flags like a status change
// - any set flag raises the fault alert summary bit
// - alert output low while summary and not masked
module typec_state_fault_status
(
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic reg_rd_i,
	input wire logic reg_wr_i,
	input wire typec_state_fault_pkg::reg_addr_t reg_addr_i,
	output logic [7:0] reg_rdata_o,
	input wire logic orient_i,
	input wire logic role_config_register_i,
	input wire typec_state_fault_pkg::state_code_t state_code_normal_i,
	input wire typec_state_fault_pkg::state_code_t state_code_standby_i,
	input wire logic [7:0] fault_status_register_i,
	input wire logic over_temp_i,
	input wire logic fault_alert_mask_i,
	output logic active_line_select_o,
	output typec_state_fault_pkg::state_code_t connection_state_code_o,
	output logic orientation_o,
	output logic fault_alert_summary_o,
	output logic alert_n_o
);
	import typec_state_fault_pkg::*;

	bank_state_s q;
	bank_state_s next_q;
	state_code_t sel_code;
	reg_byte_t set_vec;
	logic rd_fault;
	logic rd_op;

	change_if #(.WIDTH(8)) fault_chg ();
	change_if #(.WIDTH(1)) heat_chg ();

	change_sync #(.WIDTH(8)) u_fault_sync
	(
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.async_i(fault_status_register_i),
		.chg(fault_chg)
	);

	change_sync #(.WIDTH(1)) u_heat_sync
	(
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.async_i(over_temp_i),
		.chg(heat_chg)
	);

	function automatic logic code_defined(input state_code_t c);
		logic ok;
		ok = 1'b0;
		unique case (c)
			`CODE_UNATT_SRC,
			`CODE_WAIT_SRC,
			`CODE_ATT_SRC,
			`CODE_UNATT_ACC,
			`CODE_WAIT_ACC,
			`CODE_AUDIO_ACC,
			`CODE_UNORIENT_DBG,
			`CODE_ERR_RECOVERY,
			`CODE_UNATT_WAIT,
			`CODE_ORIENT_DBG:
				ok = 1'b1;
			default:
				ok = 1'b0;
		endcase
		return ok;
	endfunction

	// variant selected by the role configuration
	assign sel_code = role_config_register_i ? state_code_standby_i : state_code_normal_i;

	assign rd_fault = reg_rd_i && (reg_addr_i == `OFF_FAULT_CHANGE);
	assign rd_op = reg_rd_i && (reg_addr_i == `OFF_OPERATION_STATE);

	// flags raised this cycle
	always_comb
	begin
		set_vec = `FLAGS_RESET;
		set_vec[`FLT_THERMAL_BIT] = heat_chg.level[0];
		set_vec[`FLT_PU_OVP_BIT] = fault_chg.change[`STS_PU_OVP];
		set_vec[`FLT_PU_GOOD_BIT] = fault_chg.change[`STS_PU_GOOD];
		set_vec[`FLT_REV_BIT] = fault_chg.change[`STS_REV_1]
			| fault_chg.change[`STS_REV_2];
		set_vec[`FLT_OCP_BIT] = fault_chg.change[`STS_OCP_1]
			| fault_chg.change[`STS_OCP_2];
		set_vec[`FLT_OVP_BIT] = fault_chg.change[`STS_OVP_1]
			| fault_chg.change[`STS_OVP_2];
	end

	always_comb
	begin
		next_q = q;
		if (ce_i)
		begin
			next_q.line_sel = orient_i;
			if (code_defined(sel_code))
				next_q.code = sel_code;
			// writes are ignored: no write path exists
			if (rd_op)
				next_q.rdata = {q.line_sel, `OP_RSVD_ZERO, q.code};
			else if (rd_fault)
				next_q.rdata = q.flags;
			else if (reg_rd_i)
				next_q.rdata = `BYTE_ZERO;
			// set wins over the clearing read
			next_q.flags = (rd_fault ? `FLAGS_RESET : q.flags) | set_vec;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			q.line_sel <= 1'b0;
			q.code <= `OP_STATE_RESET;
			q.flags <= `FLAGS_RESET;
			q.rdata <= `BYTE_ZERO;
		end
		else
			q <= next_q;
	end

	assign reg_rdata_o = q.rdata;
	assign active_line_select_o = q.line_sel;
	assign orientation_o = q.line_sel;
	assign connection_state_code_o = q.code;
	assign fault_alert_summary_o = |q.flags;
	// only the fault summary feeds the alert, never the operation status
	assign alert_n_o = !(fault_alert_summary_o && !fault_alert_mask_i);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_write_no_effect: assert property (reg_wr_i && !reg_rd_i |=> $stable(reg_rdata_o))
		else $error("write changed read data");

	a_line_matches_pin: assert property (active_line_select_o == orientation_o)
		else $error("line bit differs from orientation pin");

	a_line_follows_in: assert property (ce_i |=> active_line_select_o == $past(orient_i))
		else $error("line bit did not follow orientation");

	a_code_follows_mode: assert property (ce_i && code_defined(sel_code)
		|=> connection_state_code_o == $past(sel_code))
		else $error("state code did not follow selected variant");

	a_code_reserved_hold: assert property (ce_i && !code_defined(sel_code)
		|=> $stable(connection_state_code_o))
		else $error("reserved state code reported");

	a_read_returns_flags: assert property (ce_i && rd_fault
		|=> reg_rdata_o == $past(q.flags))
		else $error("fault read returned wrong value");

	a_read_clears_flags: assert property (ce_i && rd_fault
		|=> q.flags == $past(set_vec))
		else $error("clearing read lost or kept flags");

	a_op_read_value: assert property (ce_i && rd_op
		|=> reg_rdata_o == {$past(q.line_sel), `OP_RSVD_ZERO, $past(q.code)})
		else $error("operation status read wrong");

	a_unmapped_zero: assert property (ce_i && reg_rd_i && !rd_fault && !rd_op
		|=> reg_rdata_o == `BYTE_ZERO)
		else $error("unmapped read not zero");

	a_rdata_holds: assert property (!(ce_i && reg_rd_i)
		|=> $stable(reg_rdata_o))
		else $error("read data changed without a read");

	a_op_rsvd_bits: assert property (ce_i && rd_op
		|=> (reg_rdata_o & 8'h60) == `BYTE_ZERO)
		else $error("operation status reserved bits set");

	a_code_legal: assert property (code_defined(connection_state_code_o)
		)
		else $error("reported state code is reserved");

	a_normal_variant: assert property (ce_i && !role_config_register_i
		&& code_defined(state_code_normal_i) |=> connection_state_code_o == $past(state_code_normal_i))
		else $error("normal variant not reported");

	a_standby_variant: assert property (ce_i && role_config_register_i
		&& code_defined(state_code_standby_i) |=> connection_state_code_o == $past(state_code_standby_i))
		else $error("standby variant not reported");

	a_line_bit_read: assert property (ce_i && rd_op
		|=> reg_rdata_o[`OP_LINE_BIT] == $past(orientation_o))
		else $error("read line bit differs from pin");

	a_no_spurious: assert property (ce_i && !rd_fault && set_vec == `FLAGS_RESET
		|=> $stable(q.flags))
		else $error("flag set without a change");

	a_flags_kept: assert property (ce_i && !rd_fault
		|=> (q.flags & $past(q.flags)) == $past(q.flags))
		else $error("flag cleared without a read");

	a_write_no_flags: assert property (ce_i && reg_wr_i && !reg_rd_i
		|=> (q.flags & $past(q.flags)) == $past(q.flags))
		else $error("write cleared flags");

	a_clear_empty: assert property (ce_i && rd_fault && set_vec == `FLAGS_RESET
		|=> !fault_alert_summary_o)
		else $error("summary stayed after clearing read");

	a_thermal_cleared: assert property (ce_i && rd_fault && !heat_chg.level[0]
		|=> !q.flags[`FLT_THERMAL_BIT])
		else $error("thermal flag not cleared when cool");

	a_read_keeps_set: assert property (ce_i && rd_fault && set_vec[`FLT_PU_OVP_BIT]
		|=> q.flags[`FLT_PU_OVP_BIT])
		else $error("change lost in clearing read");

	a_change_latches: assert property (ce_i && (|fault_chg.change) |=> fault_alert_summary_o)
		else $error("status change not latched");

	a_thermal_sets: assert property (ce_i && heat_chg.level[0]
		|=> q.flags[`FLT_THERMAL_BIT])
		else $error("over temperature flag missing");

	a_pullup_ovp_map: assert property (ce_i && fault_chg.change[`STS_PU_OVP]
		|=> q.flags[`FLT_PU_OVP_BIT])
		else $error("pull-up overvoltage change lost");

	a_pullup_good_map: assert property (ce_i && fault_chg.change[`STS_PU_GOOD]
		|=> q.flags[`FLT_PU_GOOD_BIT])
		else $error("pull-up good change lost");

	a_reverse_map: assert property (ce_i && fault_chg.change[`STS_REV_2]
		|=> q.flags[`FLT_REV_BIT])
		else $error("reverse voltage change lost");

	a_reverse_one_map: assert property (ce_i && fault_chg.change[`STS_REV_1]
		|=> q.flags[`FLT_REV_BIT])
		else $error("first line reverse voltage change lost");

	a_overcurrent_map: assert property (ce_i && fault_chg.change[`STS_OCP_1]
		|=> q.flags[`FLT_OCP_BIT])
		else $error("overcurrent change lost");

	a_overcurrent_two_map: assert property (ce_i && fault_chg.change[`STS_OCP_2]
		|=> q.flags[`FLT_OCP_BIT])
		else $error("second line overcurrent change lost");

	a_overvolt_map: assert property (ce_i && fault_chg.change[`STS_OVP_2]
		|=> q.flags[`FLT_OVP_BIT])
		else $error("overvoltage change lost");

	a_overvolt_one_map: assert property (ce_i && fault_chg.change[`STS_OVP_1]
		|=> q.flags[`FLT_OVP_BIT])
		else $error("first line overvoltage change lost");

	a_thermal_alerts: assert property (ce_i && heat_chg.level[0] && !fault_alert_mask_i
		|=> !alert_n_o || $past(fault_alert_mask_i) != fault_alert_mask_i)
		else $error("over temperature did not alert");

	a_mask_quiet: assert property (fault_alert_mask_i |-> alert_n_o
		)
		else $error("masked alert asserted");

	a_unmasked_alert: assert property (fault_alert_summary_o && !fault_alert_mask_i
		|-> !alert_n_o)
		else $error("unmasked summary did not alert");

	a_idle_no_alert: assert property (!fault_alert_summary_o |-> alert_n_o
		)
		else $error("alert without fault summary");

	a_summary_steady: assert property (ce_i && !rd_fault && set_vec == `FLAGS_RESET
		|=> $stable(fault_alert_summary_o))
		else $error("summary moved without an event");

	a_rsvd_never_set: assert property (!set_vec[`FLT_RSVD_HI_BIT]
		&& !set_vec[`FLT_RSVD_LO_BIT])
		else $error("reserved flag raised");

	a_summary_bit: assert property (fault_alert_summary_o == (q.flags != `FLAGS_RESET))
		else $error("summary bit wrong");

	a_alert_pin: assert property (!alert_n_o == (fault_alert_summary_o && !fault_alert_mask_i))
		else $error("alert pin wrong");

	a_op_no_alert: assert property ($changed(connection_state_code_o) && $stable(q.flags)
		&& $stable(fault_alert_mask_i) |-> $stable(alert_n_o))
		else $error("operation status raised alert");

	a_reserved_zero: assert property (!q.flags[`FLT_RSVD_HI_BIT] && !q.flags[`FLT_RSVD_LO_BIT])
		else $error("reserved flag set");

	c_read_with_set: cover property (ce_i && rd_fault && (set_vec != `FLAGS_RESET));
	c_thermal_alert: cover property (ce_i && heat_chg.level[0] ##1 !alert_n_o);
	c_attached: cover property (connection_state_code_o == `CODE_ATT_SRC && active_line_select_o);
	c_reserved_in: cover property (ce_i && !code_defined(sel_code));
	c_standby_mode: cover property (ce_i && role_config_register_i && code_defined(sel_code));
endmodule
